// ### logic/asa_assembler.sv
// Receive-side string assembler: collects characters into padded strings
// How it works
// - A string longer than the set length sends that many characters at once.
// - Overlength detection sets the overlength flag in the first status word.
// - The overlength flag clears when the host acknowledges the transfer.
// - Characters not sent after an overlength transfer stay buffered.
// - Leftovers go out with new data at full length or on delimiter.
// - The first extra character triggers the transfer and starts the leftover.
// - Characters equal to the removal character are dropped on entry.
// - Dropped characters are replaced by padding after justification.
// - Padding is the space character.
// - The end-of-string delimiter is never passed to the host.
// - Justify left when the margin bit is set, otherwise right.
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "asa_defines.svh"

module asa_assembler #(
	parameter int MAX_LEN = 64,
	parameter int IN_AW = 7,
	parameter int OUT_AW = 5
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic charValid,
	input wire logic [6:0] charData,
	output logic charReady,
	input wire logic [5:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	output logic irq,
	output logic stringDone,
	output logic overlengthFlag
);

	localparam int CW = IN_AW;
	localparam logic [CW-1:0] MAX_LEN_C = CW'(MAX_LEN);
	localparam logic [CW-1:0] ONE_C = CW'(1);

	// ------------------------------------------------------------------
	// State and decoded configuration
	// ------------------------------------------------------------------
	asa_pkg::asa_word_t firstInitWordQ, secondInitWordQ;
	asa_pkg::asa_word_t thirdInitWordQ, fourthInitWordQ;
	logic inputOverlengthFlagQ, readyFlagQ, irqQ, rdMemQ, doneQ;
	logic [1:0] irqStatQ, irqMaskQ;
	logic [15:0] regRdataQ;
	asa_pkg::asa_state_t stateQ;
	logic [IN_AW-1:0] wrPtrQ, rdPtrQ;
	logic [CW-1:0] countQ, nQ, padQ, lenQ, kQ, s2KQ;
	logic carryQ, readyQ, leftQ, s2ValidQ, s2DataQ;
	logic [7:0] hiQ;
	logic [`ASA_LEN_MSB:0] lenReg;
	logic [CW-1:0] lenEff, slotN;
	logic removeEn, marginJustifyBit;
	logic [6:0] removalCharField, delimChar;

	assign lenReg = secondInitWordQ[`ASA_LEN_MSB:0];
	assign removeEn = firstInitWordQ[`ASA_WORDS_MSB:0] == `ASA_WORDS_FOUR;
	assign removalCharField =
		fourthInitWordQ[`ASA_CHAR_MSB:`ASA_CHAR_LSB];
	assign delimChar = thirdInitWordQ[`ASA_CHAR_MSB:`ASA_CHAR_LSB];
	assign marginJustifyBit = thirdInitWordQ[`ASA_JUST_BIT];

	// Zero length would never complete; oversize is clipped to the buffer
	assign lenEff = (lenReg == '0) ? ONE_C :
		(lenReg > (`ASA_LEN_MSB + 1)'(MAX_LEN)) ? MAX_LEN_C :
		lenReg[CW-1:0];
	// Right-justified data end in the last byte of a whole word
	assign slotN = marginJustifyBit ? lenEff :
		lenEff + CW'(lenEff[0]);

	// ------------------------------------------------------------------
	// Character intake and trigger decisions
	// ------------------------------------------------------------------
	logic accept, isDelim, isRemoved, append;
	logic hitOver, hitFull, hitDelim, trig;
	logic [CW-1:0] cntPlus, sendN;

	assign accept = charValid && readyQ;
	assign isDelim = charData == delimChar;
	// Delimiter wins if both characters are configured alike
	assign isRemoved = removeEn && !isDelim &&
		(charData == removalCharField);
	assign append = accept && !isDelim && !isRemoved;
	assign cntPlus = countQ + ONE_C;
	// Fresh string: the first character past the length triggers
	assign hitOver = append && !carryQ && (cntPlus > lenEff);
	// Carried string: completes as soon as the length is reached
	assign hitFull = append && carryQ && (cntPlus >= lenEff);
	assign hitDelim = accept && isDelim;
	assign trig = hitOver || hitFull || hitDelim;
	assign sendN = hitDelim ? countQ : lenEff;

	// ------------------------------------------------------------------
	// Copy pipeline: issue stage reads input buffer, stage two packs
	// ------------------------------------------------------------------
	logic issuing, issueData, s2Last, finish, outWr;
	logic [7:0] inRdata, outChar;
	logic [OUT_AW-1:0] outWrAddr;
	logic [15:0] outWrData, outRdata;

	assign issuing = (stateQ == asa_pkg::ST_COPY) && (kQ != lenQ);
	// Removed characters never entered, so padding replaces them
	assign issueData = leftQ ? (kQ < nQ) : (kQ >= padQ);
	assign s2Last = s2ValidQ && (s2KQ == lenQ - ONE_C);
	assign finish = s2Last;
	assign outChar = s2DataQ ? inRdata : `ASA_SPACE;
	assign outWr = s2ValidQ && (s2KQ[0] || s2Last);
	assign outWrAddr = OUT_AW'(s2KQ >> 1);
	// Odd length: final word gets a space in its lower byte
	assign outWrData = s2KQ[0] ? {hiQ, outChar} :
		{outChar, `ASA_SPACE};

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hiQ <= `ASA_NUL;
		end else if (s2ValidQ && !s2KQ[0]) begin
			hiQ <= outChar;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s2ValidQ <= 1'b0;
			s2DataQ <= 1'b0;
			s2KQ <= '0;
		end else begin
			s2ValidQ <= issuing;
			s2DataQ <= issueData;
			s2KQ <= kQ;
		end
	end

	// ------------------------------------------------------------------
	// Transfer control
	// ------------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stateQ <= asa_pkg::ST_IDLE;
			nQ <= '0;
			padQ <= '0;
			lenQ <= '0;
			kQ <= '0;
			leftQ <= 1'b0;
		end else begin
			unique case (stateQ)
				asa_pkg::ST_IDLE: begin
					if (trig) begin
						stateQ <= asa_pkg::ST_COPY;
						nQ <= sendN;
						padQ <= slotN - sendN;
						lenQ <= slotN;
						kQ <= '0;
						leftQ <= marginJustifyBit;
					end
				end
				asa_pkg::ST_COPY: begin
					if (issuing) begin
						kQ <= kQ + ONE_C;
					end
					if (finish) begin
						stateQ <= asa_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// Intake stalls for the whole copy; the source sees it on charReady
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			readyQ <= 1'b0;
		end else begin
			readyQ <= !trig && (finish || stateQ == asa_pkg::ST_IDLE);
		end
	end

	// ------------------------------------------------------------------
	// Input buffer pointers and fill count
	// ------------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wrPtrQ <= '0;
		end else if (append) begin
			wrPtrQ <= wrPtrQ + IN_AW'(1);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdPtrQ <= '0;
		end else if (issuing && issueData) begin
			rdPtrQ <= rdPtrQ + IN_AW'(1);
		end
	end

	// Appends and finish never meet: intake is stalled during copy
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			countQ <= '0;
		end else if (append) begin
			countQ <= cntPlus;
		end else if (finish) begin
			countQ <= countQ - nQ;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			carryQ <= 1'b0;
		end else if (hitOver) begin
			carryQ <= 1'b1;
		end else if (hitFull || hitDelim) begin
			carryQ <= 1'b0;
		end
	end

	asa_char_mem #(.WIDTH(8), .AW(IN_AW)) u_in_mem (
		.clk(clk), .sys_rst(sys_rst), .wrEn(append), .wrAddr(wrPtrQ),
		.wrData({1'b0, charData}), .rdAddr(rdPtrQ), .rdData(inRdata)
	);

	// Host may read mid-copy and see a mix of old and new words
	asa_char_mem #(.WIDTH(16), .AW(OUT_AW)) u_out_mem (
		.clk(clk), .sys_rst(sys_rst), .wrEn(outWr),
		.wrAddr(outWrAddr), .wrData(outWrData),
		.rdAddr(regAddr[OUT_AW-1:0]), .rdData(outRdata)
	);

	// ------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------
	logic regWin, ackWr;

	assign regWin = regAddr[`ASA_WIN_BIT];
	assign ackWr = regWr && (regAddr == `ASA_ADDR_ACK);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			firstInitWordQ <= `ASA_RST_INIT1;
			secondInitWordQ <= `ASA_RST_INIT2;
			thirdInitWordQ <= `ASA_RST_INIT3;
			fourthInitWordQ <= `ASA_RST_INIT4;
			irqMaskQ <= `ASA_RST_IRQ;
		end else if (regWr) begin
			unique case (regAddr)
				`ASA_ADDR_INIT1: firstInitWordQ <= regWdata;
				`ASA_ADDR_INIT2: secondInitWordQ <= regWdata;
				`ASA_ADDR_INIT3: thirdInitWordQ <= regWdata;
				`ASA_ADDR_INIT4: fourthInitWordQ <= regWdata;
				`ASA_ADDR_IRQ_MASK: irqMaskQ <= regWdata[1:0];
				default: ;
			endcase
		end
	end

	// Set beats the acknowledge that lands in the same cycle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			inputOverlengthFlagQ <= 1'b0;
		end else if (hitOver) begin
			inputOverlengthFlagQ <= 1'b1;
		end else if (ackWr) begin
			inputOverlengthFlagQ <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			readyFlagQ <= 1'b0;
		end else if (finish) begin
			readyFlagQ <= 1'b1;
		end else if (ackWr) begin
			readyFlagQ <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------------
	logic [1:0] irqEvents, irqClear;

	assign irqEvents = {hitOver, finish};
	assign irqClear = (regWr && regAddr == `ASA_ADDR_IRQ_STAT) ?
		regWdata[1:0] : 2'h0;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irqStatQ <= `ASA_RST_IRQ;
		end else begin
			irqStatQ <= (irqStatQ & ~irqClear) | irqEvents;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irqQ <= 1'b0;
		end else begin
			irqQ <= |(irqStatQ & irqMaskQ);
		end
	end

	// ------------------------------------------------------------------
	// Register reads
	// ------------------------------------------------------------------
	asa_pkg::asa_word_t firstStatusWord, readMux;

	always_comb begin
		firstStatusWord = '0;
		firstStatusWord[`ASA_OVER_BIT] = inputOverlengthFlagQ;
		firstStatusWord[`ASA_READY_BIT] = readyFlagQ;
		firstStatusWord[`ASA_BUSY_BIT] = stateQ == asa_pkg::ST_COPY;
	end

	always_comb begin
		unique case (regAddr)
			`ASA_ADDR_INIT1: readMux = firstInitWordQ;
			`ASA_ADDR_INIT2: readMux = secondInitWordQ;
			`ASA_ADDR_INIT3: readMux = thirdInitWordQ;
			`ASA_ADDR_INIT4: readMux = fourthInitWordQ;
			`ASA_ADDR_STATUS1: readMux = firstStatusWord;
			`ASA_ADDR_IRQ_STAT: readMux = {14'h0000, irqStatQ};
			`ASA_ADDR_IRQ_MASK: readMux = {14'h0000, irqMaskQ};
			`ASA_ADDR_COUNT: readMux = 16'(countQ);
			default: readMux = '0;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			regRdataQ <= '0;
			rdMemQ <= 1'b0;
		end else begin
			regRdataQ <= (regRd && !regWin) ? readMux : '0;
			rdMemQ <= regRd && regWin;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			doneQ <= 1'b0;
		end else begin
			doneQ <= finish;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// Window data come from the memory's own read register
	assign regRdata = rdMemQ ? outRdata : regRdataQ;
	assign charReady = readyQ;
	assign irq = irqQ;
	assign stringDone = doneQ;
	assign overlengthFlag = inputOverlengthFlagQ;

endmodule // asa_assembler

// ### logic/asa_defines.svh
// Register offsets, field positions and reset values of the string assembler
`ifndef ASA_DEFINES_SVH
`define ASA_DEFINES_SVH

// ----------------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------------
`define ASA_ADDR_INIT1 6'h00
`define ASA_ADDR_INIT2 6'h01
`define ASA_ADDR_INIT3 6'h02
`define ASA_ADDR_INIT4 6'h03
`define ASA_ADDR_STATUS1 6'h04
`define ASA_ADDR_IRQ_STAT 6'h05
`define ASA_ADDR_IRQ_MASK 6'h06
`define ASA_ADDR_ACK 6'h07
`define ASA_ADDR_COUNT 6'h08
// Address bit that selects the output string window
`define ASA_WIN_BIT 5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ASA_RST_INIT1 16'h0000
`define ASA_RST_INIT2 16'h000F
`define ASA_RST_INIT3 16'h0D00
`define ASA_RST_INIT4 16'h0000
`define ASA_RST_IRQ 2'h0

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ASA_LEN_MSB 11
`define ASA_CHAR_MSB 14
`define ASA_CHAR_LSB 8
`define ASA_JUST_BIT 3
`define ASA_WORDS_MSB 1
`define ASA_WORDS_FOUR 2'h3
`define ASA_OVER_BIT 12
`define ASA_READY_BIT 0
`define ASA_BUSY_BIT 1
`define ASA_EV_DONE 0
`define ASA_EV_OVER 1

// ----------------------------------------------------------------------
// Characters
// ----------------------------------------------------------------------
`define ASA_SPACE 8'h20
`define ASA_NUL 8'h00

`endif

// ### logic/asa_pkg.sv
// Types shared by the string assembler files
package asa_pkg;

	typedef enum logic {
		ST_IDLE,
		ST_COPY
	} asa_state_t;

	typedef logic [15:0] asa_word_t;

endpackage

// ### logic/asa_char_mem.sv
// Simple one-write, one-read memory with registered read data
`timescale 1ns/10ps

module asa_char_mem #(
	parameter int WIDTH = 8,
	parameter int AW = 7
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic [AW-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);

	logic [WIDTH-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdData <= '0;
		end else begin
			rdData <= mem[rdAddr];
		end
	end

endmodule // asa_char_mem

// ### verif/asa_char_src.sv
// Character source model standing in for the attached ASCII device
`timescale 1ns/10ps

module asa_char_src (
	input wire logic clk,
	input wire logic charReady,
	output logic charValid,
	output logic [6:0] charData
);
	initial begin
		charValid = 1'b0;
		charData = 7'h00;
	end

	// Call just after an edge; returns at the edge that took the char
	task automatic put(input logic [6:0] c, output bit ok);
		int n;
		n = 0;
		charValid <= 1'b1;
		charData <= c;
		do begin
			@(posedge clk);
			n++;
		end while (charReady !== 1'b1 && n < 300);
		ok = (charReady === 1'b1);
	endtask

	// Released line shows a changing value, never a stale char
	task automatic idle();
		charValid <= 1'b0;
		charData <= ~charData;
	endtask
endmodule // asa_char_src

// ### verif/asa_assembler_sva.sv
// Port checker for the string assembler
`timescale 1ns/10ps

module asa_assembler_sva #(
	parameter int MAX_LEN = 64
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic charValid,
	input wire logic [6:0] charData,
	input wire logic charReady,
	input wire logic [5:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [15:0] regRdata,
	input wire logic irq,
	input wire logic stringDone,
	input wire logic overlengthFlag
);
	localparam int COPY_MAX = MAX_LEN + 6;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 16'h0000)
		else $error("read data not zero outside answer cycle");
	a_ack_read: assert property (regRd && regAddr == 6'h07 |=>
		regRdata == 16'h0000)
		else $error("ack register did not read zero");
	a_copy_bound: assert property ($fell(charReady) |-> ##[1:COPY_MAX] stringDone)
		else $error("string copy did not finish in time");
	a_copy_hold: assert property ($fell(charReady) |-> !charReady until stringDone)
		else $error("char taken during copy");
	a_done_ready: assert property (stringDone |-> charReady && !$past(charReady))
		else $error("done pulse not at end of copy");
	a_done_pulse: assert property (stringDone |=> !stringDone)
		else $error("done pulse longer than one cycle");
	a_over_set: assert property ($rose(overlengthFlag) |->
		$past(charValid && charReady) || $past(charValid && charReady, 2))
		else $error("overlength flag set without a char");
	a_over_clear: assert property ((regWr && regAddr == 6'h07 &&
		!(charValid && charReady)) ##1 !(charValid && charReady)
		|=> !overlengthFlag)
		else $error("overlength flag not cleared by ack");
	a_mask_irq: assert property ((regWr && regAddr == 6'h06 &&
		regWdata == 16'h0000) ##1 !regWr |=> ##1 !irq)
		else $error("irq high with all events masked");
endmodule // asa_assembler_sva

bind asa_assembler asa_assembler_sva #(.MAX_LEN(MAX_LEN)) chk (.clk(clk),
	.sys_rst(sys_rst), .charValid(charValid), .charData(charData),
	.charReady(charReady), .regAddr(regAddr), .regWdata(regWdata),
	.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq),
	.stringDone(stringDone), .overlengthFlag(overlengthFlag));

// ### verif/testbench.sv
// Self-checking bench for the string assembler
`timescale 1ns/10ps

module testbench;
	localparam int LEN = 15;
	logic clk;
	logic sys_rst;
	logic charValid;
	logic [6:0] charData;
	logic charReady;
	logic [5:0] regAddr;
	logic [15:0] regWdata;
	logic regWr;
	logic regRd;
	logic [15:0] regRdata;
	logic irq;
	logic stringDone;
	logic overlengthFlag;
	int failures;
	int compares;
	int doneCnt;
	logic [15:0] rv;

	asa_assembler uut (.clk(clk), .sys_rst(sys_rst), .charValid(charValid),
		.charData(charData), .charReady(charReady), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .irq(irq), .stringDone(stringDone),
		.overlengthFlag(overlengthFlag));
	asa_char_src src (.clk(clk), .charReady(charReady),
		.charValid(charValid), .charData(charData));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk) begin
		if (stringDone === 1'b1) begin
			doneCnt <= doneCnt + 1;
		end
	end

	task automatic print_verdict();
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string msg);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic bail(input string msg);
		failures++;
		$display("[FAIL] %0t %s timed out", $time, msg);
		print_verdict();
	endtask

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] a, output logic [15:0] d);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		@(posedge clk);
		d = regRdata;
	endtask

	// Sends the text, then the delimiter if asked, and waits for n strings
	task automatic send(input string s, input bit delim, input int n);
		logic [7:0] b;
		bit ok;
		int k;
		for (int i = 0; i < s.len(); i++) begin
			b = s[i];
			src.put(b[6:0], ok);
			if (!ok) bail("char");
		end
		if (delim) begin
			src.put(7'h0D, ok);
			if (!ok) bail("delimiter");
		end
		src.idle();
		k = 0;
		while (doneCnt < n && k < 300) begin
			@(posedge clk);
			k++;
		end
		if (doneCnt < n) bail("string done");
	endtask

	// Host copies each string out before the next one arrives
	task automatic check_str(input string d, input bit left);
		logic [7:0] c [0:15];
		int pad;
		// Right-justified text ends in the last byte of the last word
		pad = LEN + LEN % 2 - d.len();
		for (int i = 0; i < 16; i++) begin
			c[i] = 8'h20;
			if (left && i < d.len()) c[i] = d[i];
			if (!left && i >= pad) c[i] = d[i - pad];
		end
		for (int i = 0; i < 8; i++) begin
			rd(6'h20 + 6'(i), rv);
			chk(rv, {c[2*i], c[2*i+1]}, "word");
		end
	endtask

	task automatic t_reset();
		logic [5:0] ra [7] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h07, 6'h08,
			6'h10};
		logic [15:0] re [7] = '{16'h0000, 16'h000F, 16'h0D00, 16'h0000,
			16'h0000, 16'h0000, 16'h0000};
		for (int i = 0; i < 7; i++) begin
			rd(ra[i], rv);
			chk(rv, re[i], "reset value");
		end
	endtask

	task automatic t_left();
		wr(6'h02, 16'h0D08);
		wr(6'h06, 16'h0001);
		send("12345", 1'b1, doneCnt + 1);
		check_str("12345", 1'b1);
		chk({15'h0000, irq}, 16'h0001, "irq on done");
		wr(6'h05, 16'h0003);
		rd(6'h05, rv);
		chk(rv, 16'h0000, "irq status cleared");
		chk({15'h0000, irq}, 16'h0000, "irq after clear");
	endtask

	task automatic t_right();
		wr(6'h06, 16'h0000);
		wr(6'h02, 16'h0D00);
		send("12345", 1'b1, doneCnt + 1);
		check_str("12345", 1'b0);
		chk({15'h0000, irq}, 16'h0000, "masked irq");
		rd(6'h05, rv);
		chk(rv, 16'h0001, "done status");
		wr(6'h05, 16'h0001);
	endtask

	task automatic t_over();
		int n;
		n = doneCnt;
		wr(6'h02, 16'h0D08);
		send("01234567890123456789", 1'b0, n + 1);
		chk({15'h0000, overlengthFlag}, 16'h0001, "flag port");
		rd(6'h04, rv);
		chk(rv & 16'h1000, 16'h1000, "status flag");
		rd(6'h05, rv);
		chk(rv & 16'h0002, 16'h0002, "overlength event");
		rd(6'h08, rv);
		chk(rv, 16'h0005, "leftover count");
		check_str("012345678901234", 1'b1);
		wr(6'h07, 16'h0000);
		rd(6'h04, rv);
		chk(rv & 16'h1000, 16'h0000, "flag after ack");
		chk({15'h0000, overlengthFlag}, 16'h0000, "port after ack");
		send("", 1'b1, n + 2);
		check_str("56789", 1'b1);
		wr(6'h05, 16'h0003);
	endtask

	task automatic t_strip();
		wr(6'h00, 16'h0003);
		wr(6'h03, 16'h2F00);
		wr(6'h02, 16'h0D00);
		send("//AS//23//AS//4", 1'b1, doneCnt + 1);
		check_str("AS23AS4", 1'b0);
	endtask

	initial begin
		sys_rst = 1'b1;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 6'h00;
		regWdata = 16'h0000;
		failures = 0;
		compares = 0;
		doneCnt = 0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_left();
		t_right();
		t_over();
		t_strip();
		print_verdict();
	end
endmodule // testbench
